/* File: core/glpg_pkg.sv */
// Constants shared by the glue logic power gating block
package glpg_pkg;
  localparam int AXI_ADDR_W = 4;
  localparam int AXI_DATA_W = 32;
  localparam int BANK_W = 3;
  localparam int SLOT_N = 3;
  localparam int NIBBLE_W = 8;

  // Register byte addresses
  localparam logic [AXI_ADDR_W-1:0] BANK_OFFSET = 4'h0;
  localparam logic [AXI_ADDR_W-1:0] STATUS_OFFSET = 4'h4;

  // Bank latch layout and preset: bit16 high, bit15 low, bit14 high
  localparam int BANK_TOP_BIT = 2;
  localparam logic [BANK_W-1:0] BANK_RESET = 3'h5;

  // Status register field positions
  localparam int ST_BANK_LSB = 0;
  localparam int ST_POWER_OFF = 3;
  localparam int ST_WEAK_BATTERY = 4;
  localparam int ST_PORT_SELECT = 5;
  localparam int ST_READ_DRIVE = 6;
  localparam int ST_RETURN_DRIVE = 7;

  // Memory window split by the top bank bit (address bits 15 and 14)
  localparam logic [1:0] WINDOW_A15_A14 = 2'h1;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

/* File: core/glpg_top.sv */
// Gate array glue: bank latch, bus gating, serial routing, power clamps
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
// Summary of operation
// RL1 - Power off holds outputs at fixed levels; break key, inverted address 13 and bank outputs still follow their inputs
// RL2 - Weak battery: slots high, break low, strobe released
// RL3 - Break key output is inverse of key
// RL4 - Inverted address 13 output complements input
// RL5 - Latch strobe marks main write to port 3DH
// RL6 - Bank outputs latch data bits 2..0
// RL7 - Top bank bit splits 16KB window at 4000H
// RL8 - System reset low presets bank to 101
// RL9 - Return enable low drives return nibbles out
// RL10 - Power off forces data bits 2..0 low
// RL11 - UART clock passes sub clock when on
// RL12 - Slot selects follow inputs when healthy
// RL13 - Slot selects high when off or weak
// RL14 - Read strobe from five inputs, hi-Z otherwise
// RL15 - Strobe low only during secondary processor reads
// RL16 - Port select swaps optical and RS-232 lines
// RL17 - Gating combinational except the bank latch
module glpg_top
  import glpg_pkg::*;
#(
  parameter int BANK_BITS = BANK_W,
  parameter int SLOTS = SLOT_N
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // AXI4-Lite slave
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Power and key
  input wire logic power_off_flag,
  input wire logic weak_battery_in,
  input wire logic on_key_n,
  output logic break_key_to_sub,
  // Address and bank
  input wire logic addr13,
  input wire logic addr15,
  input wire logic addr14,
  output logic inverted_addr13,
  input wire logic latch_strobe,
  input wire logic system_reset_n,
  output logic [BANK_BITS-1:0] latched_bank_bits,
  output logic window_lower_sel_n,
  output logic window_upper_sel_n,
  // Main processor data bus, bits 7..0
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic [7:0] data_oe,
  input wire logic return_data_enable_n,
  input wire logic [NIBBLE_W-1:0] return_nibbles,
  // Read strobe for the secondary processor
  input wire logic mem_enable_zero,
  input wire logic mem_enable_one,
  input wire logic cpu_read_timing_n,
  input wire logic clock_phase_in,
  input wire logic bus_request_in,
  output logic read_strobe_n_out,
  output logic read_strobe_n_oe,
  // Clock and serial routing
  input wire logic sub_clock_in,
  output logic uart_clock_out,
  input wire logic serial_port_select,
  input wire logic uart_tx_in,
  output logic uart_rx_out,
  output logic rs232_tx_out,
  output logic optical_tx_out,
  input wire logic rs232_rx_in,
  input wire logic optical_rx_in,
  // Slot selects
  input wire logic [SLOTS-1:0] slot_select_in,
  output logic [SLOTS-1:0] slot_select_out
);

  function automatic logic addr_hit(
    input logic [AXI_ADDR_W-1:0] addr,
    input logic [AXI_ADDR_W-1:0] offset
  );
    addr_hit = (addr[AXI_ADDR_W-1:2] == offset[AXI_ADDR_W-1:2]);
  endfunction

  logic [BANK_BITS-1:0] bank_q;
  logic [BANK_BITS-1:0] bank_d;
  logic aw_held_q;
  logic aw_held_d;
  logic w_held_q;
  logic w_held_d;
  logic [AXI_ADDR_W-1:0] awaddr_q;
  logic [AXI_ADDR_W-1:0] awaddr_d;
  logic [AXI_DATA_W-1:0] wdata_q;
  logic [AXI_DATA_W-1:0] wdata_d;
  logic [3:0] wstrb_q;
  logic [3:0] wstrb_d;
  logic bvalid_q;
  logic bvalid_d;
  logic [1:0] bresp_q;
  logic [1:0] bresp_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [1:0] rresp_q;
  logic [1:0] rresp_d;
  logic [AXI_DATA_W-1:0] rdata_q;
  logic [AXI_DATA_W-1:0] rdata_d;
  logic system_off;
  logic secondary_owns_bus;
  logic read_cycle;
  logic sw_bank_write;
  logic [AXI_DATA_W-1:0] status_word;

  assign system_off = power_off_flag | weak_battery_in;
  // Secondary processor has the bus while the request line is high and power is neither off nor weak
  assign secondary_owns_bus = bus_request_in & ~system_off;
  // Only a true memory or I/O read while the read phase is active
  assign read_cycle = (mem_enable_zero | mem_enable_one) & ~cpu_read_timing_n
    & clock_phase_in; // [RL15]

  // Pin gating: purely combinational paths [RL17]
  always_comb
  begin
    inverted_addr13 = ~addr13; // [RL4]
    break_key_to_sub = weak_battery_in ? 1'b0 : ~on_key_n; // [RL3] [RL2]
    uart_clock_out = power_off_flag ? 1'b0 : sub_clock_in; // [RL11] [RL1]
    if (system_off)
    begin
      slot_select_out = {SLOTS{1'b1}}; // [RL13] [RL2]
    end
    else
    begin
      slot_select_out = slot_select_in; // [RL12]
    end
    read_strobe_n_oe = secondary_owns_bus; // [RL14] [RL2]
    read_strobe_n_out = ~(read_cycle & secondary_owns_bus); // [RL14]
    if (power_off_flag)
    begin
      rs232_tx_out = 1'b0; // [RL1]
      optical_tx_out = 1'b0;
      uart_rx_out = 1'b0;
    end
    else if (!serial_port_select)
    begin
      rs232_tx_out = 1'b0; // [RL16]
      optical_tx_out = uart_tx_in;
      uart_rx_out = optical_rx_in;
    end
    else
    begin
      rs232_tx_out = uart_tx_in; // [RL16]
      optical_tx_out = 1'b0;
      uart_rx_out = rs232_rx_in;
    end
  end

  // Data bus drive: return nibbles on read, clamp low while off
  always_comb
  begin
    data_out = 8'h00;
    data_oe = 8'h00;
    if (power_off_flag)
    begin
      data_out = 8'h00; // [RL10]
      data_oe = 8'h07; // [RL10] [RL1]
    end
    else if (!return_data_enable_n)
    begin
      data_out = return_nibbles; // [RL9]
      data_oe = 8'hff; // [RL9]
    end
  end

  // Bank window split: top bank bit picks the half of 4000H..7FFFH
  always_comb
  begin
    window_lower_sel_n = 1'b1;
    window_upper_sel_n = 1'b1;
    if (!power_off_flag && ({addr15, addr14} == WINDOW_A15_A14))
    begin
      window_lower_sel_n = bank_q[BANK_TOP_BIT]; // [RL7]
      window_upper_sel_n = ~bank_q[BANK_TOP_BIT]; // [RL7]
    end
  end

  assign latched_bank_bits = bank_q; // [RL6]

  // Write channel: address and data accepted in either order
  assign sw_bank_write = aw_held_q & w_held_q & ~bvalid_q
    & addr_hit(awaddr_q, BANK_OFFSET) & wstrb_q[0];

  always_comb
  begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (aw_held_q && w_held_q && !bvalid_q)
    begin
      bvalid_d = 1'b1;
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      if (addr_hit(awaddr_q, BANK_OFFSET) || addr_hit(awaddr_q, STATUS_OFFSET))
      begin
        bresp_d = RESP_OKAY;
      end
      else
      begin
        bresp_d = RESP_DECERR;
      end
    end
    else if (bvalid_q && s_axi_bready)
    begin
      bvalid_d = 1'b0;
    end
  end

  // Bank latch: reset preset, port strobe, then software write
  always_comb
  begin
    bank_d = bank_q;
    if (!system_reset_n)
    begin
      bank_d = BANK_RESET; // [RL8]
    end
    else if (latch_strobe)
    begin
      bank_d = data_in[BANK_BITS-1:0]; // [RL5] [RL6]
    end
    else if (sw_bank_write)
    begin
      bank_d = wdata_q[BANK_BITS-1:0];
    end
  end

  // Status word shows the block's live state
  always_comb
  begin
    status_word = '0;
    status_word[ST_BANK_LSB +: BANK_W] = bank_q[BANK_W-1:0];
    status_word[ST_POWER_OFF] = power_off_flag;
    status_word[ST_WEAK_BATTERY] = weak_battery_in;
    status_word[ST_PORT_SELECT] = serial_port_select;
    status_word[ST_READ_DRIVE] = secondary_owns_bus;
    status_word[ST_RETURN_DRIVE] = ~return_data_enable_n & ~power_off_flag;
  end

  // Read channel: one read at a time, answered the next cycle
  always_comb
  begin
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_d = 1'b1;
      if (addr_hit(s_axi_araddr, BANK_OFFSET))
      begin
        rdata_d = {{(AXI_DATA_W-BANK_BITS){1'b0}}, bank_q};
        rresp_d = RESP_OKAY;
      end
      else if (addr_hit(s_axi_araddr, STATUS_OFFSET))
      begin
        rdata_d = status_word;
        rresp_d = RESP_OKAY;
      end
      else
      begin
        rdata_d = '0;
        rresp_d = RESP_DECERR;
      end
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_d = 1'b0;
    end
  end

  assign s_axi_awready = ~aw_held_q & ~bvalid_q;
  assign s_axi_wready = ~w_held_q & ~bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      bank_q <= BANK_RESET; // [RL8]
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
    end
    else if (clk_en)
    begin
      bank_q <= bank_d;
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

endmodule

/* File: tb/glpg_top_chk.sv */
// Concurrent checks on the glue logic pins and bank latch
`timescale 1ns/1ps
module glpg_top_chk
  import glpg_pkg::*;
#(
  parameter int BANK_BITS = BANK_W,
  parameter int SLOTS = SLOT_N
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic power_off_flag,
  input wire logic weak_battery_in,
  input wire logic on_key_n,
  input wire logic break_key_to_sub,
  input wire logic addr13,
  input wire logic inverted_addr13,
  input wire logic latch_strobe,
  input wire logic system_reset_n,
  input wire logic [BANK_BITS-1:0] latched_bank_bits,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic [7:0] data_oe,
  input wire logic bus_request_in,
  input wire logic read_strobe_n_oe,
  input wire logic sub_clock_in,
  input wire logic uart_clock_out,
  input wire logic [SLOTS-1:0] slot_select_in,
  input wire logic [SLOTS-1:0] slot_select_out
);
  wire [2:0] data_low = data_in[2:0];
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  brk_key_a: assert property (
    break_key_to_sub == (!on_key_n && !weak_battery_in)) else $error("break key level wrong");
  inv_addr_a: assert property (
    inverted_addr13 != addr13) else $error("inverted address wrong");
  uart_clk_a: assert property (
    uart_clock_out == (sub_clock_in && !power_off_flag)) else $error("uart clock wrong");
  slot_gate_a: assert property (
    (power_off_flag || weak_battery_in) ? slot_select_out == '1 : slot_select_out == slot_select_in)
    else $error("slot select wrong");
  data_clamp_a: assert property (
    power_off_flag |-> data_oe == 8'h07 && data_out == 8'h00) else $error("data clamp wrong");
  strobe_rel_a: assert property (
    (!bus_request_in || weak_battery_in || power_off_flag) |-> !read_strobe_n_oe)
    else $error("read strobe not released");
  bank_pre_a: assert property (
    clk_en && !system_reset_n |=> latched_bank_bits == BANK_RESET) else $error("bank preset wrong");
  bank_load_a: assert property (
    clk_en && system_reset_n && latch_strobe |=> latched_bank_bits == $past(data_low))
    else $error("bank latch wrong");
  bank_hold_a: assert property (
    !clk_en |=> $stable(latched_bank_bits)) else $error("bank changed while frozen");
  cover property (power_off_flag);
  cover property (weak_battery_in && !power_off_flag);
  cover property (latch_strobe && system_reset_n);
endmodule

bind glpg_top glpg_top_chk #(.BANK_BITS(BANK_BITS), .SLOTS(SLOTS)) chk (.*);

/* File: tb/glpg_sub_model.sv */
// Sub controller model: divided clock and ever-changing return nibbles
`timescale 1ns/1ps
module glpg_sub_model
(
  input wire logic clk,
  output logic sub_clock_in = 1'b0,
  output logic [7:0] return_nibbles = 8'h00
);
  logic [1:0] div_q = 2'h0;
  always @(posedge clk)
  begin
    div_q <= div_q + 2'h1;
    sub_clock_in <= div_q[1];
    return_nibbles <= return_nibbles + 8'h35;
  end
endmodule

/* File: tb/test_glue_logic_power_gating.sv */
// Self-checking bench for the glue logic power gating block
`timescale 1ns/1ps
module test_glue_logic_power_gating;
  import glpg_pkg::*;
  logic clk, reset, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic power_off_flag, weak_battery_in, on_key_n, break_key_to_sub, addr13, addr15, addr14;
  logic inverted_addr13, latch_strobe, system_reset_n, window_lower_sel_n, window_upper_sel_n;
  logic return_data_enable_n, mem_enable_zero, mem_enable_one, cpu_read_timing_n;
  logic clock_phase_in, bus_request_in, read_strobe_n_out, read_strobe_n_oe, sub_clock_in;
  logic uart_clock_out, serial_port_select, uart_tx_in, uart_rx_out, rs232_tx_out;
  logic optical_tx_out, rs232_rx_in, optical_rx_in;
  logic [2:0] latched_bank_bits, slot_select_in, slot_select_out, bexp;
  logic [7:0] data_in, data_out, data_oe, return_nibbles;
  logic [33:0] q[$];
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  glpg_top uut (.*);
  glpg_sub_model sub (.clk(clk), .sub_clock_in(sub_clock_in), .return_nibbles(return_nibbles));
  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task wrap_up;
    if (error_cnt == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task cmp(input string n, input logic [33:0] x, input logic [33:0] s);
    compares++;
    if (s !== x)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      error_cnt++;
      wrap_up;
    end
  end
  always @(posedge clk)
    if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
      cmp("axi", q.pop_front(), s_axi_bvalid ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata});
  task wr(input logic [3:0] a, input logic [31:0] d);
    logic ap, wp;
    begin
      @(posedge clk);
      ap = 1;
      wp = 1;
      q.push_back({RESP_OKAY, 32'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      while (ap || wp)
      begin
        @(posedge clk);
        if (ap && s_axi_awready)
        begin
          ap = 0;
          s_axi_awvalid <= 0;
        end
        if (wp && s_axi_wready)
        begin
          wp = 0;
          s_axi_wvalid <= 0;
        end
      end
      do @(posedge clk); while (!s_axi_bvalid);
      s_axi_bready <= 0;
    end
  endtask
  task rd(input logic [3:0] a, input logic [33:0] x);
    @(posedge clk);
    q.push_back(x);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 0;
  endtask
  task pins(input int n);
    logic p, w, s;
    logic [33:0] x;
    repeat (n)
    begin
      {power_off_flag, weak_battery_in, on_key_n, addr13, addr15, addr14, return_data_enable_n,
        mem_enable_zero, mem_enable_one, cpu_read_timing_n, clock_phase_in, bus_request_in,
        serial_port_select, uart_tx_in, rs232_rx_in, optical_rx_in, slot_select_in} <= 19'($urandom);
      @(negedge clk);
      p = power_off_flag;
      w = weak_battery_in;
      s = bus_request_in & ~p & ~w;
      x = {5'h0, ~on_key_n & ~w, ~addr13,
        (!p && {addr15, addr14} == WINDOW_A15_A14) ? {bexp[2], ~bexp[2]} : 2'h3,
        p ? 8'h07 : {8{~return_data_enable_n}}, (p | return_data_enable_n) ? 8'h00 : return_nibbles,
        s, ~((mem_enable_zero | mem_enable_one) & ~cpu_read_timing_n & clock_phase_in & s),
        sub_clock_in & ~p, p ? 3'h0 : serial_port_select ? {rs232_rx_in, uart_tx_in, 1'b0} :
        {optical_rx_in, 1'b0, uart_tx_in}, (p | w) ? 3'h7 : slot_select_in};
      cmp("pins", x, {5'h0, break_key_to_sub, inverted_addr13, window_lower_sel_n,
        window_upper_sel_n, data_oe, data_out, read_strobe_n_oe, read_strobe_n_out, uart_clock_out,
        uart_rx_out, rs232_tx_out, optical_tx_out, slot_select_out});
      @(posedge clk);
    end
  endtask
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready, s_axi_araddr,
      s_axi_arvalid, s_axi_rready, power_off_flag, weak_battery_in, addr13, addr15, addr14,
      latch_strobe, data_in, mem_enable_zero, mem_enable_one, clock_phase_in, bus_request_in,
      serial_port_select, uart_tx_in, rs232_rx_in, optical_rx_in, slot_select_in} = '0;
    {reset, clk_en, on_key_n, system_reset_n, return_data_enable_n, cpu_read_timing_n} = '1;
    s_axi_wstrb = 4'hf;
    void'($urandom(39));
    repeat (20) @(posedge clk);
    reset <= 0;
    rd(BANK_OFFSET, {RESP_OKAY, 32'h5});
    rd(4'h8, {RESP_DECERR, 32'h0});
    wr(BANK_OFFSET, 32'hfffffff2);
    rd(BANK_OFFSET, {RESP_OKAY, 32'h2});
    wr(STATUS_OFFSET, 32'hffffffff);
    rd(STATUS_OFFSET, {RESP_OKAY, 32'h2});
    bexp = 3'h2;
    pins(150);
    data_in <= 8'($urandom);
    latch_strobe <= 1;
    @(posedge clk);
    latch_strobe <= 0;
    bexp = data_in[2:0];
    rd(BANK_OFFSET, {RESP_OKAY, 29'h0, bexp});
    // Strobe while the clock enable is low must leave the latch untouched
    clk_en <= 0;
    latch_strobe <= 1;
    data_in <= ~data_in;
    @(posedge clk);
    clk_en <= 1;
    latch_strobe <= 0;
    rd(BANK_OFFSET, {RESP_OKAY, 29'h0, bexp});
    system_reset_n <= 0;
    @(posedge clk);
    system_reset_n <= 1;
    bexp = BANK_RESET;
    rd(BANK_OFFSET, {RESP_OKAY, 29'h0, bexp});
    // Status flags: on, port select high, bus owned, return data driven
    {power_off_flag, weak_battery_in, serial_port_select, bus_request_in,
      return_data_enable_n} <= 5'h06;
    rd(STATUS_OFFSET, {RESP_OKAY, 32'he5});
    // Status flags: off and weak, so neither drive is reported
    {power_off_flag, weak_battery_in, serial_port_select, bus_request_in,
      return_data_enable_n} <= 5'h1e;
    rd(STATUS_OFFSET, {RESP_OKAY, 32'h3d});
    pins(150);
    wrap_up;
  end
endmodule
